// *** ccad_consts.vh ***
/*
 Constants for the conversion control and auxiliary decimator core.
 Assumes inclusion by bare name from a file that needs these macros.
*/
`ifndef CCAD_CONSTS_VH
`define CCAD_CONSTS_VH
// Register byte offsets on the plain register port.
`define CCAD_OFF_MODE_REGISTER_ZERO 4'h0
`define CCAD_OFF_AUXCFG 4'h4
`define CCAD_OFF_STATUS 4'h8
`define CCAD_OFF_AUXDATA 4'hc
// Field positions and reset values.
`define CCAD_BIT_STYLE 6
`define CCAD_MODE_REGISTER_ZERO_RST 8'h00
`define CCAD_AUXCFG_RST 8'h00
`define CCAD_ST_MAIN 0
`define CCAD_ST_AUX 1
`define CCAD_ST_NEW 2
`define CCAD_ST_READY_N 3
// Aux rate select codes.
`define CCAD_RATE_10 2'b00
`define CCAD_RATE_100 2'b01
`define CCAD_RATE_400 2'b10
`define CCAD_RATE_800 2'b11
// Divider, stop setup and conversion in master-clock periods; first-stage decimation in samples, second-stage decimation and settle count in first-stage outputs.
`define CCAD_MOD_DIV 144
`define CCAD_DEC_A_512 512
`define CCAD_DEC_A_128 128
`define CCAD_DEC_A_64 64
`define CCAD_DEC_B 10
`define CCAD_STOP_SETUP 16
`define CCAD_MAIN_CONV 1024
`define CCAD_SETTLE 2'd3
// First seven opcode bits, captured on the seventh falling edge.
`define CCAD_OP_MAIN_BEGIN 7'h04
`define CCAD_OP_MAIN_HALT 7'h05
`define CCAD_OP_AUX_BEGIN 7'h06
`define CCAD_OP_AUX_HALT 7'h07
`endif

// *** ccad_core.v ***
/*
 Main conversion control and auxiliary sinc3/sinc1 decimator.
 Assumes clk_i is the master clock; start pin and serial pins are
 asynchronous, aux_mod_bit_i comes from logic on clk_i.
*/
`include "ccad_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module ccad_core #(
  parameter MOD_DIV = `CCAD_MOD_DIV,
  parameter MAIN_CONV_CYCLES = `CCAD_MAIN_CONV,
  parameter STOP_SETUP = `CCAD_STOP_SETUP
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Pins
  input wire start_pin_i,
  input wire sclk_i,
  input wire sdi_i,
  input wire cs_n_i,
  output wire result_ready_n_o,
  // Aux modulator and main active flag
  input wire aux_mod_bit_i,
  output wire aux_sample_o,
  output wire main_active_o,
  // Register port
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rdata_o
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;
  localparam [7:0] MOD_LAST = MOD_DIV - 1;
  localparam [19:0] CONV_LAST = MAIN_CONV_CYCLES - 1;
  localparam [19:0] LATE_AT = MAIN_CONV_CYCLES - STOP_SETUP;
  localparam [19:0] REARM_AT = MAIN_CONV_CYCLES / 2;
  localparam [3:0] B_LAST = `CCAD_DEC_B - 1;

  // Decimation count minus one for the first stage.
  function [9:0] dec_last;
    input [1:0] rate;
    begin
      case (rate)
        `CCAD_RATE_800: dec_last = `CCAD_DEC_A_64 - 1;
        `CCAD_RATE_400: dec_last = `CCAD_DEC_A_128 - 1;
        default: dec_last = `CCAD_DEC_A_512 - 1;
      endcase
    end
  endfunction

  // Left shift that brings every sinc3 gain to full scale of 2^27.
  function [3:0] norm_shift;
    input [1:0] rate;
    begin
      case (rate)
        `CCAD_RATE_800: norm_shift = 4'h9;
        `CCAD_RATE_400: norm_shift = 4'h6;
        default: norm_shift = 4'h0;
      endcase
    end
  endfunction

  // Division by ten through a fixed-point reciprocal; the error stays
  // below one part in ten thousand and never overflows 24 bits.
  function [23:0] div10;
    input [27:0] sum;
    reg [40:0] prod;
    begin
      prod = sum * 13'h199a;
      div10 = prod[39:16];
    end
  endfunction

  // Synchronisers: stage 0 feeds only stage 1.
  reg [2:0] start_s_q;
  reg [2:0] sclk_s_q;
  reg [1:0] sdi_s_q;
  reg [1:0] cs_s_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_s_q <= 3'h0;
      sclk_s_q <= 3'h0;
      sdi_s_q <= 2'h0;
      cs_s_q <= 2'h3;
    end else begin
      start_s_q <= {start_s_q[1:0], start_pin_i};
      sclk_s_q <= {sclk_s_q[1:0], sclk_i};
      sdi_s_q <= {sdi_s_q[0], sdi_i};
      cs_s_q <= {cs_s_q[0], cs_n_i};
    end
  end

  wire pin_rise = start_s_q[1] & ~start_s_q[2];
  wire pin_fall = ~start_s_q[1] & start_s_q[2];
  wire sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];

  // Serial opcode capture.
  reg [2:0] bitcnt_q;
  reg [5:0] shift_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bitcnt_q <= 3'h0;
      shift_q <= 6'h00;
    end else if (cs_s_q[1]) begin
      bitcnt_q <= 3'h0;
    end else if (sclk_fall) begin
      bitcnt_q <= bitcnt_q + 3'h1;
      shift_q <= {shift_q[4:0], sdi_s_q[1]};
    end
  end

  wire [6:0] op7 = {shift_q, sdi_s_q[1]};
  wire op_take = sclk_fall & ~cs_s_q[1] & (bitcnt_q == 3'h6);
  wire main_begin = op_take & (op7 == `CCAD_OP_MAIN_BEGIN);
  wire main_halt = op_take & (op7 == `CCAD_OP_MAIN_HALT);
  wire aux_begin = op_take & (op7 == `CCAD_OP_AUX_BEGIN);
  wire aux_halt = op_take & (op7 == `CCAD_OP_AUX_HALT);

  // Registers.
  reg [7:0] mode_register_zero_q;
  reg [7:0] auxcfg_q;
  reg [31:0] rdata_q;
  wire cfg_wr = wr_i & (addr_i == `CCAD_OFF_AUXCFG);
  wire data_rd = rd_i & (addr_i == `CCAD_OFF_AUXDATA);
  wire style_pulse = mode_register_zero_q[`CCAD_BIT_STYLE];
  wire [1:0] rate = auxcfg_q[1:0];

  // Main converter control; the pin acts here only, opcodes here and on the aux converter.
  wire start_ev = pin_rise | main_begin;
  wire stop_ev = pin_fall | main_halt;
  reg [1:0] mst_q;
  reg [19:0] mcnt_q;
  reg pulse_q;
  reg stop_pend_q;
  reg stop_late_q;
  reg ready_n_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mst_q <= ST_IDLE;
      mcnt_q <= 20'h0;
      pulse_q <= 1'b0;
      stop_pend_q <= 1'b0;
      stop_late_q <= 1'b0;
      ready_n_q <= 1'b1;
    end else begin
      case (mst_q)
        ST_IDLE: begin
          if (start_ev) begin
            mst_q <= ST_CONV;
            mcnt_q <= 20'h0;
            pulse_q <= style_pulse;
            stop_pend_q <= 1'b0;
            stop_late_q <= 1'b0;
            ready_n_q <= 1'b1;
          end
        end
        ST_CONV: begin
          if (start_ev) begin
            // A fresh start restarts the conversion under way.
            mcnt_q <= 20'h0;
            pulse_q <= style_pulse;
            stop_pend_q <= 1'b0;
            stop_late_q <= 1'b0;
            ready_n_q <= 1'b1;
          end else if (mcnt_q == CONV_LAST) begin
            ready_n_q <= 1'b0;
            mcnt_q <= 20'h0;
            stop_late_q <= 1'b0;
            // A stop inside the setup window carries into the next one.
            if (pulse_q | stop_pend_q) begin
              mst_q <= ST_IDLE;
              stop_pend_q <= 1'b0;
            end else begin
              stop_pend_q <= stop_late_q | (stop_ev & ~pulse_q);
            end
          end else begin
            mcnt_q <= mcnt_q + 20'h1;
            if (mcnt_q == REARM_AT && !pulse_q) begin
              ready_n_q <= 1'b1;
            end
            if (stop_ev && !pulse_q) begin
              if (mcnt_q < LATE_AT) begin
                stop_pend_q <= 1'b1;
              end else begin
                stop_late_q <= 1'b1;
              end
            end
          end
        end
        default: mst_q <= ST_IDLE;
      endcase
    end
  end

  // Aux converter, controlled by opcodes only.
  reg aux_run_q;
  reg [7:0] mdiv_q;
  reg samp_q;
  reg [29:0] i1_q;
  reg [29:0] i2_q;
  reg [29:0] i3_q;
  reg [29:0] d1_q;
  reg [29:0] d2_q;
  reg [29:0] d3_q;
  reg [9:0] dcnt_q;
  reg [1:0] settle_q;
  reg [27:0] s2sum_q;
  reg [3:0] s2cnt_q;
  reg [23:0] aux_data_q;
  reg aux_new_q;

  wire clr = aux_begin | aux_halt | cfg_wr;
  wire [29:0] c1 = i3_q - d1_q;
  wire [29:0] c2 = c1 - d2_q;
  wire [29:0] c3 = c2 - d3_q;
  wire [27:0] c3n = c3[27:0] << norm_shift(rate);
  wire [23:0] s1 = c3n[27:4];
  wire [27:0] s2next = s2sum_q + {4'h0, s1};
  wire dec_hit = samp_q & (dcnt_q == dec_last(rate));
  wire out_ok = dec_hit & (settle_q == `CCAD_SETTLE);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_run_q <= 1'b0;
      mdiv_q <= 8'h00;
      samp_q <= 1'b0;
    end else begin
      if (aux_begin) begin
        aux_run_q <= 1'b1;
      end else if (aux_halt) begin
        aux_run_q <= 1'b0;
      end
      mdiv_q <= (mdiv_q == MOD_LAST || clr) ? 8'h00 : mdiv_q + 8'h01;
      samp_q <= aux_run_q & ~clr & (mdiv_q == MOD_LAST);
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      i1_q <= 30'h0;
      i2_q <= 30'h0;
      i3_q <= 30'h0;
      d1_q <= 30'h0;
      d2_q <= 30'h0;
      d3_q <= 30'h0;
      dcnt_q <= 10'h0;
      settle_q <= 2'd0;
      s2sum_q <= 28'h0;
      s2cnt_q <= 4'h0;
    end else if (clr) begin
      // Rate change or start flushes the filter and its settling count.
      i1_q <= 30'h0;
      i2_q <= 30'h0;
      i3_q <= 30'h0;
      d1_q <= 30'h0;
      d2_q <= 30'h0;
      d3_q <= 30'h0;
      dcnt_q <= 10'h0;
      settle_q <= 2'd0;
      s2sum_q <= 28'h0;
      s2cnt_q <= 4'h0;
    end else if (samp_q) begin
      i1_q <= i1_q + {29'h0, aux_mod_bit_i};
      i2_q <= i2_q + i1_q;
      i3_q <= i3_q + i2_q;
      if (dec_hit) begin
        dcnt_q <= 10'h0;
        d1_q <= i3_q;
        d2_q <= c1;
        d3_q <= c2;
        if (settle_q != `CCAD_SETTLE) begin
          settle_q <= settle_q + 2'd1;
        end else if (rate == `CCAD_RATE_10) begin
          s2sum_q <= (s2cnt_q == B_LAST) ? 28'h0 : s2next;
          s2cnt_q <= (s2cnt_q == B_LAST) ? 4'h0 : s2cnt_q + 4'h1;
        end
      end else begin
        dcnt_q <= dcnt_q + 10'h1;
      end
    end
  end

  wire aux_load = out_ok & ((rate != `CCAD_RATE_10) | (s2cnt_q == B_LAST));

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_data_q <= 24'h0;
      aux_new_q <= 1'b0;
    end else begin
      if (aux_load) begin
        // The whole word changes in one edge.
        aux_data_q <= (rate == `CCAD_RATE_10) ? div10(s2next) : s1;
        aux_new_q <= 1'b1;
      end else if (data_rd) begin
        aux_new_q <= 1'b0;
      end
    end
  end

  // Register port; read data stand for one cycle only.
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_register_zero_q <= `CCAD_MODE_REGISTER_ZERO_RST;
      auxcfg_q <= `CCAD_AUXCFG_RST;
      rdata_q <= 32'h0;
    end else begin
      if (wr_i && addr_i == `CCAD_OFF_MODE_REGISTER_ZERO) begin
        mode_register_zero_q <= wdata_i[7:0];
      end
      if (cfg_wr) begin
        auxcfg_q <= wdata_i[7:0];
      end
      if (rd_i) begin
        case (addr_i)
          `CCAD_OFF_MODE_REGISTER_ZERO: rdata_q <= {24'h0, mode_register_zero_q};
          `CCAD_OFF_AUXCFG: rdata_q <= {24'h0, auxcfg_q};
          `CCAD_OFF_STATUS: rdata_q <= {28'h0, ready_n_q, aux_new_q, aux_run_q, mst_q[1]};
          `CCAD_OFF_AUXDATA: rdata_q <= {8'h0, aux_data_q};
          default: rdata_q <= 32'h0;
        endcase
      end else begin
        rdata_q <= 32'h0;
      end
    end
  end

  assign result_ready_n_o = ready_n_q;
  assign aux_sample_o = samp_q;
  assign main_active_o = mst_q[1];
  assign rdata_o = rdata_q;

endmodule
`default_nettype wire

// *** ccad_core_assertions.sv ***
/*
 Port checker for the conversion core.
 Assumes it is bound to the core and that ports keep their declared widths.
*/
`timescale 1ns/10ps
`default_nettype none
module ccad_core_chk #(
  parameter MOD_DIV = 144,
  parameter MAIN_CONV_CYCLES = 1024,
  parameter STOP_SETUP = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins
  input wire logic start_pin_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  input wire logic cs_n_i,
  input wire logic result_ready_n_o,
  // Aux modulator and main active flag
  input wire logic aux_mod_bit_i,
  input wire logic aux_sample_o,
  input wire logic main_active_o,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic pulse_q;
  logic [8:0] gap_q;
  // The style bit is shadowed from writes because the register is not visible here.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_q <= 1'b0;
      gap_q <= 9'h1ff;
    end else begin
      if (wr_i && addr_i == 4'h0) begin
        pulse_q <= wdata_i[6];
      end
      if (aux_sample_o) begin
        gap_q <= 9'h000;
      end else if (gap_q != 9'h1ff) begin
        gap_q <= gap_q + 9'h001;
      end
    end
  end
  sequence s_pin_start;
    $rose(start_pin_i) ##1 start_pin_i [*3];
  endsequence
  sequence s_conv_go;
    main_active_o && result_ready_n_o;
  endsequence
  property p_rdata_idle;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_aux_width;
    rd_i && addr_i == 4'hc |=> rdata_o[31:24] == 8'h00;
  endproperty
  a_aux_width: assert property (p_aux_width) else $error("aux word too wide");
  property p_aux_period;
    aux_sample_o && gap_q != 9'h1ff |-> gap_q == MOD_DIV - 1;
  endproperty
  a_aux_period: assert property (p_aux_period) else $error("aux sample spacing");
  property p_start_ready;
    $rose(main_active_o) |-> result_ready_n_o;
  endproperty
  a_start_ready: assert property (p_start_ready) else $error("ready low at start");
  property p_pin_start;
    s_pin_start |-> ##[0:3] s_conv_go;
  endproperty
  a_pin_start: assert property (p_pin_start) else $error("pin start too slow");
  property p_pulse_single;
    pulse_q && $fell(result_ready_n_o) |-> ##[0:2] !main_active_o;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("pulse kept running");
  property p_ready_stands;
    $fell(result_ready_n_o) |=> !result_ready_n_o [*8];
  endproperty
  a_ready_stands: assert property (p_ready_stands) else $error("ready pulse short");
  property p_pulse_stop;
    pulse_q && $fell(main_active_o) |-> !result_ready_n_o;
  endproperty
  a_pulse_stop: assert property (p_pulse_stop) else $error("pulse aborted");
endmodule
bind ccad_core ccad_core_chk #(.MOD_DIV(MOD_DIV), .MAIN_CONV_CYCLES(MAIN_CONV_CYCLES),
  .STOP_SETUP(STOP_SETUP)) u_ccad_core_chk (.clk_i(clk_i), .rst_i(rst_i),
  .start_pin_i(start_pin_i), .sclk_i(sclk_i), .sdi_i(sdi_i), .cs_n_i(cs_n_i),
  .result_ready_n_o(result_ready_n_o), .aux_mod_bit_i(aux_mod_bit_i),
  .aux_sample_o(aux_sample_o), .main_active_o(main_active_o), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
`default_nettype wire

// *** ccad_host.sv ***
/*
 Host model driving the start pin and serial opcodes.
 Assumes its tasks are called from the bench after reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ccad_host (
  // Clock
  input wire logic clk_i,
  // Pins to the device
  output logic start_pin_o,
  output logic sclk_o,
  output logic sdi_o,
  output logic cs_n_o
);
  initial begin
    start_pin_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b1;
    cs_n_o = 1'b1;
  end
  // Each level is held four clocks so the pin stays legal.
  task automatic set_pin(input logic v);
    @(posedge clk_i) start_pin_o <= v;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // The serial clock is offset from the master clock so the phases never line up.
  task automatic send_op(input logic [7:0] op);
    @(posedge clk_i) cs_n_o <= 1'b0;
    #1.5;
    for (int i = 7; i >= 0; i--) begin
      sdi_o = op[i];
      #16 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
      #16;
    end
    cs_n_o = 1'b1;
    sdi_o = ~op[0];
  endtask
endmodule
`default_nettype wire

// *** testbench.sv ***
/*
 Self-checking bench for the conversion core.
 Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic mod_bit_i = 1'b1;
  wire start_pin, sclk, sdi, cs_n, ready_n, aux_sample, main_active;
  wire [31:0] rdata_o;
  int n_errors = 0;
  int compares = 0;
  always #2 clk_i = ~clk_i;
  // A shorter conversion keeps the run brief; the modulator input stays at full scale.
  ccad_core #(.MAIN_CONV_CYCLES(256)) u_ccad_core (.clk_i(clk_i), .rst_i(rst_i),
    .start_pin_i(start_pin), .sclk_i(sclk), .sdi_i(sdi), .cs_n_i(cs_n),
    .result_ready_n_o(ready_n), .aux_mod_bit_i(mod_bit_i), .aux_sample_o(aux_sample),
    .main_active_o(main_active), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o));
  ccad_host u_ccad_host (.clk_i(clk_i), .start_pin_o(start_pin), .sclk_o(sclk),
    .sdi_o(sdi), .cs_n_o(cs_n));
  task summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i) {wr_i, addr_i, wdata_i} <= {1'b1, a, v};
    @(posedge clk_i) wr_i <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_i) {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i) rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task wait_rdy(input logic v);
    int k;
    k = 0;
    while (ready_n !== v && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 400) begin
      n_errors++;
      summarize();
    end
  endtask
  task wait_smp(output int k);
    k = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while (aux_sample !== 1'b1 && k < 300);
    if (k == 300) begin
      n_errors++;
      summarize();
    end
  endtask
  task t_reset();
    logic [31:0] d;
    chk(ready_n, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), d);
      chk(d, i == 2 ? 32'h8 : 32'h0);
    end
    rd(4'h2, d);
    chk(d, 32'h0);
  endtask
  task t_pulse();
    logic [31:0] d;
    wr(4'h0, 32'h40);
    rd(4'h0, d);
    chk(d, 32'h40);
    u_ccad_host.set_pin(1'b1);
    chk(ready_n, 32'h1);
    chk(main_active, 32'h1);
    u_ccad_host.set_pin(1'b0);
    u_ccad_host.send_op(8'h0a);
    chk(main_active, 32'h1);
    wait_rdy(1'b0);
    repeat (3) @(posedge clk_i);
    #1 chk(main_active, 32'h0);
    repeat (300) @(posedge clk_i);
    chk(ready_n, 32'h0);
    u_ccad_host.send_op(8'h09);
    chk(ready_n, 32'h1);
    wait_rdy(1'b0);
  endtask
  task t_cont();
    logic [31:0] d;
    wr(4'h0, 32'h0);
    u_ccad_host.send_op(8'h08);
    chk(ready_n, 32'h1);
    wait_rdy(1'b0);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    chk(main_active, 32'h1);
    u_ccad_host.send_op(8'h0b);
    repeat (600) @(posedge clk_i);
    rd(4'h8, d);
    chk(d, 32'h0);
  endtask
  task t_aux();
    logic [31:0] d;
    int k;
    wr(4'h4, 32'h3);
    rd(4'h4, d);
    chk(d, 32'h3);
    u_ccad_host.send_op(8'h0c);
    wait_smp(k);
    wait_smp(k);
    chk(k, 144);
    for (k = 0; k < 60 && d[2] !== 1'b1; k++) begin
      repeat (1000) @(posedge clk_i);
      rd(4'h8, d);
    end
    if (k == 60) begin
      n_errors++;
      summarize();
    end
    chk(d[1], 32'h1);
    chk(ready_n, 32'h0);
    rd(4'hc, d);
    chk(d, 32'h800000);
    u_ccad_host.send_op(8'h0e);
    repeat (20) @(posedge clk_i);
    k = 0;
    repeat (500) @(negedge clk_i) k += aux_sample;
    chk(k, 32'h0);
    u_ccad_host.send_op(8'h0d);
    wait_smp(k);
    u_ccad_host.send_op(8'h0f);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_pulse();
    t_cont();
    t_aux();
    summarize();
  end
endmodule
`default_nettype wire
